/* File: vref_pkg.sv */
// constants shared by the voltage reference control block
// assumes a single 125 MHz peripheral clock and word-aligned bus access
`default_nettype none

package vref_pkg;

	// ************************************************************
	// clock and settling time
	// ************************************************************
	localparam int unsigned CLK_PERIOD_NS     = 8;
	localparam int unsigned SETTLE_TIME_NS    = 10000;
	// least time, so round up to whole cycles
	localparam int unsigned SETTLE_CYCLES     =
		(SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ************************************************************
	// register byte offsets and indices
	// ************************************************************
	localparam logic [11:0] OFF_FIXED_REF_CONTROL   = 12'h000;
	localparam logic [11:0] OFF_DIVIDER_REF_CONTROL = 12'h004;
	localparam logic [11:0] OFF_DIVIDER_CODE_SELECT = 12'h008;
	localparam logic [1:0]  IDX_FIXED_REF_CONTROL   = 2'h0;
	localparam logic [1:0]  IDX_DIVIDER_REF_CONTROL = 2'h1;
	localparam logic [1:0]  IDX_DIVIDER_CODE_SELECT = 2'h2;
	localparam int unsigned REG_W                   = 8;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int unsigned FIXED_EN_BIT     = 7;
	localparam int unsigned FIXED_STABLE_BIT = 6;
	localparam int unsigned FIXED_GAIN_LSB   = 4;
	localparam int unsigned DIV_EN_BIT       = 7;
	localparam int unsigned DIV_LPS_BIT      = 6;
	localparam int unsigned PIN_OE_BIT       = 5;
	localparam int unsigned DIV_PSRC_LSB     = 2;
	localparam int unsigned DIV_NSRC_BIT     = 0;
	localparam int unsigned CODE_W           = 5;

	// ************************************************************
	// reset values and reserved codes
	// ************************************************************
	localparam logic [1:0]        GAIN_RESET     = 2'h1;
	localparam logic [1:0]        GAIN_RESERVED  = 2'h0;
	localparam logic [1:0]        PSRC_RESET     = 2'h0;
	localparam logic [1:0]        PSRC_RESERVED  = 2'h3;
	localparam logic [CODE_W-1:0] CODE_RESET     = 5'h00;

endpackage

`default_nettype wire

/* File: reg_access_if.sv */
// register access carrier between the bus port and the register file
// assumes both ends run on the same peripheral clock
`timescale 1ns/1ns
`default_nettype none

interface reg_access_if;
	logic       wr_stb;
	logic [1:0] wr_idx;
	logic [7:0] wdata;
	logic [1:0] rd_idx;
	logic [7:0] rdata;

	modport bus (output wr_stb, output wr_idx, output wdata,
		output rd_idx, input rdata);
	modport regs (input wr_stb, input wr_idx, input wdata,
		input rd_idx, output rdata);
endinterface

`default_nettype wire

/* File: ahb_reg_port.sv */
// ahb-lite slave front end for the reference control registers
// assumes single word transfers; reads take one wait state
`timescale 1ns/1ns
`default_nettype none

module ahb_reg_port
	import vref_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_clk_en,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic        i_hwrite,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hready,
	input  wire logic [31:0] i_hwdata,
	output var  logic        o_hreadyout,
	output var  logic        o_hresp,
	output var  logic [31:0] o_hrdata,
	reg_access_if.bus        ra
);

	logic       wr_pend;
	logic       rd_pend;
	logic       hit_q;
	logic [1:0] idx_q;
	logic       addr_take;
	logic       next_hit;
	logic [1:0] next_idx;

	// address decode; anything else is unmapped but still answered
	always_comb
	begin
		next_hit = 1'h1;
		next_idx = IDX_FIXED_REF_CONTROL;
		case (i_haddr[11:0])
			OFF_FIXED_REF_CONTROL:   next_idx = IDX_FIXED_REF_CONTROL;
			OFF_DIVIDER_REF_CONTROL: next_idx = IDX_DIVIDER_REF_CONTROL;
			OFF_DIVIDER_CODE_SELECT: next_idx = IDX_DIVIDER_CODE_SELECT;
			default:                 next_hit = 1'h0;
		endcase
	end

	assign addr_take = i_hsel & i_htrans[1] & i_hready;

	// address phase capture and data phase sequencing
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			wr_pend     <= 1'h0;
			rd_pend     <= 1'h0;
			hit_q       <= 1'h0;
			idx_q       <= 2'h0;
			o_hreadyout <= 1'h1;
			o_hresp     <= 1'h0;
			o_hrdata    <= 32'h0;
		end
		else if (i_clk_en)
		begin
			if (rd_pend)
			begin
				// register read settles after any write just committed
				o_hrdata    <= hit_q ? {24'h0, ra.rdata} : 32'h0;
				o_hreadyout <= 1'h1;
				rd_pend     <= 1'h0;
			end
			else if (addr_take)
			begin
				hit_q       <= next_hit;
				idx_q       <= next_idx;
				wr_pend     <= i_hwrite;
				rd_pend     <= ~i_hwrite;
				o_hreadyout <= i_hwrite;
			end
			else
			begin
				wr_pend <= 1'h0;
			end
			if (rd_pend || addr_take)
				wr_pend <= ~rd_pend & addr_take & i_hwrite;
		end
	end

	// write data stands in the data phase; narrow data in low bits
	assign ra.wr_stb = wr_pend & hit_q;
	assign ra.wr_idx = idx_q;
	assign ra.wdata  = i_hwdata[7:0];
	assign ra.rd_idx = idx_q;

endmodule

`default_nettype wire

/* File: settle_timer.sv */
// settling timer for the fixed reference stability flag
// assumes the enable comes from a register on the same clock
`timescale 1ns/1ns
`default_nettype none

module settle_timer
	import vref_pkg::*;
#(
	parameter int unsigned CYCLES = SETTLE_CYCLES
)
(
	input  wire logic i_ref_clk,
	input  wire logic i_resetn,
	input  wire logic i_clk_en,
	input  wire logic i_enable,
	output var  logic o_stable
);

	localparam int unsigned CNT_W = $clog2(CYCLES + 1);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

	typedef enum logic [2:0]
	{
		ST_OFF      = 3'h1,
		ST_SETTLING = 3'h2,
		ST_STABLE   = 3'h4
	} settle_e;

	settle_e          state;
	logic [CNT_W-1:0] count;

	// disabling at any time restarts the full settling wait
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state    <= ST_OFF;
			count    <= '0;
			o_stable <= 1'h0;
		end
		else if (i_clk_en)
		begin
			case (state)
				ST_OFF:
				begin
					count    <= '0;
					o_stable <= 1'h0;
					if (i_enable)
						state <= ST_SETTLING;
				end
				ST_SETTLING:
				begin
					count <= count + 1'h1;
					if (!i_enable)
						state <= ST_OFF;
					else if (count == LAST)
					begin
						state    <= ST_STABLE;
						o_stable <= 1'h1;
					end
				end
				ST_STABLE:
				begin
					if (!i_enable)
					begin
						state    <= ST_OFF;
						o_stable <= 1'h0;
					end
				end
				default:
				begin
					state    <= ST_OFF;
					o_stable <= 1'h0;
				end
			endcase
		end
	end

	// flag never rises before the settling count has run out
	stable_early_a: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn)
		$rose(o_stable) |-> $past(count) == LAST)
	else $error("stable flag rose before settling ended");

endmodule

`default_nettype wire

/* File: voltage_reference_control.sv */
// control logic for the programmable and fixed voltage references
// assumes one peripheral clock, an ahb-lite master and pad logic outside
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module voltage_reference_control
	import vref_pkg::*;
#(
	parameter int unsigned SETTLE_COUNT = SETTLE_CYCLES
)
(
	input  wire logic              i_ref_clk,
	input  wire logic              i_resetn,
	input  wire logic              i_clk_en,
	input  wire logic              i_hsel,
	input  wire logic [31:0]       i_haddr,
	input  wire logic              i_hwrite,
	input  wire logic [1:0]        i_htrans,
	input  wire logic              i_hready,
	input  wire logic [31:0]       i_hwdata,
	output var  logic              o_hreadyout,
	output var  logic              o_hresp,
	output var  logic [31:0]       o_hrdata,
	input  wire logic              i_shared_pin,
	input  wire logic              i_port_out,
	input  wire logic              i_port_oe,
	output var  logic              o_pin_out,
	output var  logic              o_pin_oe,
	output var  logic              o_pin_input_en,
	output var  logic              o_pin_analog_connect,
	output var  logic              o_pin_read,
	output var  logic              o_fixed_ref_enable,
	output var  logic [1:0]        o_fixed_ref_gain_select,
	output var  logic              o_divider_enable,
	output var  logic              o_divider_low_power_state,
	output var  logic [1:0]        o_divider_positive_source,
	output var  logic              o_divider_negative_source,
	output var  logic [CODE_W-1:0] o_divider_code,
	output var  logic              o_divider_clamp_ground
);

	// ************************************************************
	// register state
	// ************************************************************
	logic              fixed_ref_enable;
	logic [1:0]        fixed_ref_gain_select;
	logic              fixed_ref_stable;
	logic              divider_enable;
	logic              divider_low_power_state;
	logic              ref_pin_output_enable;
	logic [1:0]        divider_positive_source;
	logic              divider_negative_source;
	logic [CODE_W-1:0] divider_code;
	logic [REG_W-1:0]  read_value;
	logic              wr_fixed;
	logic              wr_div;
	logic              wr_code;
	logic              pin_sync1;
	logic              pin_sync2;
	logic              pin_sync3;
	logic              pin_level;

	reg_access_if ra ();

	// ************************************************************
	// bus port and settling timer
	// ************************************************************
	ahb_reg_port u_bus
	(
		.i_ref_clk   (i_ref_clk),
		.i_resetn    (i_resetn),
		.i_clk_en    (i_clk_en),
		.i_hsel      (i_hsel),
		.i_haddr     (i_haddr),
		.i_hwrite    (i_hwrite),
		.i_htrans    (i_htrans),
		.i_hready    (i_hready),
		.i_hwdata    (i_hwdata),
		.o_hreadyout (o_hreadyout),
		.o_hresp     (o_hresp),
		.o_hrdata    (o_hrdata),
		.ra          (ra)
	);

	settle_timer #(.CYCLES(SETTLE_COUNT)) u_settle
	(
		.i_ref_clk (i_ref_clk),
		.i_resetn  (i_resetn),
		.i_clk_en  (i_clk_en),
		.i_enable  (fixed_ref_enable),
		.o_stable  (fixed_ref_stable)
	);

	// ************************************************************
	// register writes
	// ************************************************************
	assign wr_fixed = ra.wr_stb & (ra.wr_idx == IDX_FIXED_REF_CONTROL);
	assign wr_div   = ra.wr_stb & (ra.wr_idx == IDX_DIVIDER_REF_CONTROL);
	assign wr_code  = ra.wr_stb & (ra.wr_idx == IDX_DIVIDER_CODE_SELECT);

	// fixed reference control; a reserved gain code is dropped
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			fixed_ref_enable      <= 1'h0;
			fixed_ref_gain_select <= GAIN_RESET;
		end
		else if (i_clk_en && wr_fixed)
		begin
			fixed_ref_enable <= ra.wdata[FIXED_EN_BIT];
			if (ra.wdata[FIXED_GAIN_LSB +: 2] != GAIN_RESERVED)
				fixed_ref_gain_select <= ra.wdata[FIXED_GAIN_LSB +: 2];
		end
	end

	// divider control; only reset and writes touch it, so sleep keeps it
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			divider_enable          <= 1'h0;
			divider_low_power_state <= 1'h0;
			ref_pin_output_enable   <= 1'h0;
			divider_positive_source <= PSRC_RESET;
			divider_negative_source <= 1'h0;
		end
		else if (i_clk_en && wr_div)
		begin
			divider_enable          <= ra.wdata[DIV_EN_BIT];
			divider_low_power_state <= ra.wdata[DIV_LPS_BIT];
			ref_pin_output_enable   <= ra.wdata[PIN_OE_BIT];
			divider_negative_source <= ra.wdata[DIV_NSRC_BIT];
			// reserved source code would leave the divider unpowered
			if (ra.wdata[DIV_PSRC_LSB +: 2] != PSRC_RESERVED)
				divider_positive_source <= ra.wdata[DIV_PSRC_LSB +: 2];
		end
	end

	// divider code, right justified
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			divider_code <= CODE_RESET;
		else if (i_clk_en && wr_code)
			divider_code <= ra.wdata[CODE_W-1:0];
	end

	// ************************************************************
	// register reads
	// ************************************************************
	// stability flag is read live, not latched at write time
	always_comb
	begin
		read_value = '0;
		case (ra.rd_idx)
			IDX_FIXED_REF_CONTROL:
			begin
				read_value[FIXED_EN_BIT]          = fixed_ref_enable;
				read_value[FIXED_STABLE_BIT]      = fixed_ref_stable;
				read_value[FIXED_GAIN_LSB +: 2]   = fixed_ref_gain_select;
			end
			IDX_DIVIDER_REF_CONTROL:
			begin
				read_value[DIV_EN_BIT]        = divider_enable;
				read_value[DIV_LPS_BIT]       = divider_low_power_state;
				read_value[PIN_OE_BIT]        = ref_pin_output_enable;
				read_value[DIV_PSRC_LSB +: 2] = divider_positive_source;
				read_value[DIV_NSRC_BIT]      = divider_negative_source;
			end
			IDX_DIVIDER_CODE_SELECT:
				read_value[CODE_W-1:0] = divider_code;
			default:
				read_value = '0;
		endcase
	end

	assign ra.rdata = read_value;

	// ************************************************************
	// shared pin input synchroniser
	// ************************************************************
	// three stages; a change counts only once stages two and three agree
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			pin_sync1 <= 1'h0;
			pin_sync2 <= 1'h0;
			pin_sync3 <= 1'h0;
			pin_level <= 1'h0;
		end
		else if (i_clk_en)
		begin
			pin_sync1 <= i_shared_pin;
			pin_sync2 <= pin_sync1;
			pin_sync3 <= pin_sync2;
			if (pin_sync2 == pin_sync3)
				pin_level <= pin_sync3;
		end
	end

	// ************************************************************
	// pad control
	// ************************************************************
	// analog routing overrides whatever the port logic asks for
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_pin_out            <= 1'h0;
			o_pin_oe             <= 1'h0;
			o_pin_input_en       <= 1'h1;
			o_pin_analog_connect <= 1'h0;
			o_pin_read           <= 1'h0;
		end
		else if (i_clk_en)
		begin
			o_pin_analog_connect <= ref_pin_output_enable;
			o_pin_oe       <= ~ref_pin_output_enable & i_port_oe;
			o_pin_out      <= ~ref_pin_output_enable & i_port_out;
			o_pin_input_en <= ~ref_pin_output_enable;
			o_pin_read     <= ~ref_pin_output_enable & pin_level;
		end
	end

	// ************************************************************
	// analog control outputs
	// ************************************************************
	// registered copies so the analog side sees glitch-free levels
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_fixed_ref_enable        <= 1'h0;
			o_fixed_ref_gain_select   <= GAIN_RESET;
			o_divider_enable          <= 1'h0;
			o_divider_low_power_state <= 1'h0;
			o_divider_positive_source <= PSRC_RESET;
			o_divider_negative_source <= 1'h0;
			o_divider_code            <= CODE_RESET;
			o_divider_clamp_ground    <= 1'h1;
		end
		else if (i_clk_en)
		begin
			o_fixed_ref_enable        <= fixed_ref_enable;
			o_fixed_ref_gain_select   <= fixed_ref_gain_select;
			o_divider_enable          <= divider_enable;
			o_divider_low_power_state <= divider_low_power_state;
			o_divider_positive_source <= divider_positive_source;
			o_divider_negative_source <= divider_negative_source;
			o_divider_code            <= divider_code;
			o_divider_clamp_ground    <= ~divider_enable;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	pin_route_a: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn)
		i_clk_en |=> o_pin_analog_connect == $past(ref_pin_output_enable))
	else $error("pin routing does not follow enable bit");

	pin_override_a: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn)
		o_pin_analog_connect |-> !o_pin_oe && !o_pin_input_en)
	else $error("digital pad active while reference routed");

	pin_read_zero_a: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn)
		o_pin_analog_connect |-> !o_pin_read)
	else $error("routed pin reads nonzero");

	div_ctrl_hold_a: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn)
		!(i_clk_en && wr_div) |=>
		$stable({divider_enable, divider_low_power_state,
		ref_pin_output_enable, divider_positive_source,
		divider_negative_source}))
	else $error("divider control changed without a write");

	reset_state_a: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn)
		$rose(i_resetn) |-> !o_fixed_ref_enable && !o_divider_enable &&
		!o_pin_analog_connect && o_divider_code == CODE_RESET)
	else $error("reset state wrong after release");

	fixed_enable_wr_a: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn)
		i_clk_en && wr_fixed |=>
		fixed_ref_enable == $past(ra.wdata[FIXED_EN_BIT]) ##1
		!$past(i_clk_en) || o_fixed_ref_enable == $past(fixed_ref_enable))
	else $error("fixed enable write not applied");

	stable_off_a: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn)
		i_clk_en && !fixed_ref_enable |=> !fixed_ref_stable)
	else $error("stable flag set while fixed reference off");

	gain_reserved_a: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn)
		fixed_ref_gain_select != GAIN_RESERVED)
	else $error("gain field holds reserved code");

	div_enable_wr_a: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn)
		i_clk_en && wr_div |=>
		divider_enable == $past(ra.wdata[DIV_EN_BIT]) &&
		divider_low_power_state == $past(ra.wdata[DIV_LPS_BIT]) &&
		divider_negative_source == $past(ra.wdata[DIV_NSRC_BIT]))
	else $error("divider control write not applied");

	psrc_reserved_a: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn)
		divider_positive_source != PSRC_RESERVED)
	else $error("positive source holds reserved code");

	code_read_a: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn)
		ra.rd_idx == IDX_DIVIDER_CODE_SELECT |->
		ra.rdata == {3'h0, divider_code})
	else $error("code register read wrong");

	unimpl_zero_a: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn)
		ra.rd_idx == IDX_DIVIDER_REF_CONTROL |->
		ra.rdata[4] == 1'h0 && ra.rdata[1] == 1'h0)
	else $error("unimplemented divider control bits nonzero");

	clamp_ground_a: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn)
		o_divider_clamp_ground == !o_divider_enable)
	else $error("clamp does not follow divider enable");

	stable_live_a: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn)
		ra.rd_idx == IDX_FIXED_REF_CONTROL |->
		ra.rdata[FIXED_STABLE_BIT] == fixed_ref_stable &&
		ra.rdata[3:0] == 4'h0)
	else $error("fixed control read wrong");

endmodule

`default_nettype wire

/* File: tb_voltage_reference_control.sv */
// self-checking bench for the voltage reference control block
// assumes vref_pkg and the design files are compiled first; one clock
`timescale 1ns/1ns
`default_nettype none

`define CHK(n, e, g) \
	begin \
		cmp_count++; \
		if ((g) !== (e)) \
		begin \
			mismatches++; \
			$display("[ERR] %s expected %h seen %h", n, e, g); \
		end \
	end

module tb_voltage_reference_control
	import vref_pkg::*;
;
	// short settle count keeps the run brief
	localparam int unsigned SETTLE = 4;

	logic              ref_clk    = 1'b0;
	logic              resetn     = 1'b0;
	logic              clk_en     = 1'b1;
	logic              hsel       = 1'b0;
	logic              hwrite     = 1'b0;
	logic [1:0]        htrans     = 2'h0;
	logic [31:0]       haddr      = 32'h0;
	logic [31:0]       hwdata     = 32'h0;
	logic              shared_pin = 1'b0;
	logic              port_out   = 1'b0;
	logic              port_oe    = 1'b0;
	logic              hreadyout;
	logic              hresp;
	logic [31:0]       hrdata;
	logic              pin_out;
	logic              pin_oe;
	logic              pin_in_en;
	logic              pin_an;
	logic              pin_read;
	logic              fx_en;
	logic              dv_en;
	logic              lps;
	logic              nsrc;
	logic              clamp;
	logic [1:0]        gain;
	logic [1:0]        psrc;
	logic [CODE_W-1:0] code;
	int                mismatches = 0;
	int                cmp_count  = 0;
	int                cycles     = 0;

	voltage_reference_control #(.SETTLE_COUNT(SETTLE))
		u_voltage_reference_control
	(
		.i_ref_clk(ref_clk), .i_resetn(resetn), .i_clk_en(clk_en),
		.i_hsel(hsel), .i_haddr(haddr), .i_hwrite(hwrite),
		.i_htrans(htrans), .i_hready(hreadyout), .i_hwdata(hwdata),
		.o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
		.i_shared_pin(shared_pin), .i_port_out(port_out),
		.i_port_oe(port_oe), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
		.o_pin_input_en(pin_in_en), .o_pin_analog_connect(pin_an),
		.o_pin_read(pin_read), .o_fixed_ref_enable(fx_en),
		.o_fixed_ref_gain_select(gain), .o_divider_enable(dv_en),
		.o_divider_low_power_state(lps),
		.o_divider_positive_source(psrc),
		.o_divider_negative_source(nsrc), .o_divider_code(code),
		.o_divider_clamp_ground(clamp)
	);

	// ************************************************************
	// clock, timeout and bus tasks
	// ************************************************************
	always #4 ref_clk = ~ref_clk;

	// a hung handshake would otherwise stall the run forever
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// one single transfer; ready is sampled before the edge's updates land
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [7:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		hsel   <= 1'b1;
		haddr  <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		q = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e,
		input string n);
		logic [31:0] q;
		bus(1'b0, a, 8'h0, q);
		`CHK(n, {24'h0, e}, q)
		`CHK("hresp", 1'b0, hresp)
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// shared by power-up and mid-run reset
	task automatic chk_reset();
		rd(OFF_FIXED_REF_CONTROL, 8'h10, "fixed ctl");
		rd(OFF_DIVIDER_REF_CONTROL, 8'h00, "div ctl");
		rd(OFF_DIVIDER_CODE_SELECT, 8'h00, "code reg");
		`CHK("analog pin", 1'b0, pin_an)
		`CHK("clamp", 1'b1, clamp)
		`CHK("fixed en", 1'b0, fx_en)
		`CHK("div en", 1'b0, dv_en)
		$display("test reset values done");
	endtask

	// ************************************************************
	// test sequence
	// ************************************************************
	initial
	begin
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		chk_reset();
		// gain written as its reset code, never the reserved one; not settled
		wr(OFF_FIXED_REF_CONTROL, 8'h9f);
		rd(OFF_FIXED_REF_CONTROL, 8'h90, "early flag");
		idle(SETTLE + 4);
		rd(OFF_FIXED_REF_CONTROL, 8'hd0, "settled");
		for (int g = 1; g < 4; g++)
		begin
			wr(OFF_FIXED_REF_CONTROL, 8'(8'h80 | (g << 4)));
			idle(2);
			`CHK("gain out", 2'(g), gain)
			`CHK("fixed en", 1'b1, fx_en)
		end
		wr(OFF_FIXED_REF_CONTROL, 8'h30);
		idle(2);
		rd(OFF_FIXED_REF_CONTROL, 8'h30, "flag falls");
		$display("test fixed reference done");

		// holes written as one read back zero; no reserved source code
		wr(OFF_DIVIDER_REF_CONTROL, 8'hd3);
		idle(2);
		rd(OFF_DIVIDER_REF_CONTROL, 8'hc1, "div ctl");
		`CHK("lps", 1'b1, lps)
		`CHK("nsrc", 1'b1, nsrc)
		`CHK("div en", 1'b1, dv_en)
		`CHK("clamp", 1'b0, clamp)
		for (int p = 0; p < 3; p++)
		begin
			wr(OFF_DIVIDER_REF_CONTROL, 8'(8'h80 | (p << 2)));
			idle(2);
			`CHK("psrc", 2'(p), psrc)
			`CHK("lps", 1'b0, lps)
		end
		$display("test divider control done");

		// port drives the pin until the reference is routed
		port_oe    <= 1'b1;
		port_out   <= 1'b1;
		shared_pin <= 1'b1;
		idle(8);
		`CHK("pin oe", 1'b1, pin_oe)
		`CHK("pin out", 1'b1, pin_out)
		`CHK("pin read", 1'b1, pin_read)
		// clock enable low must freeze the synchroniser and pad flops
		clk_en     <= 1'b0;
		shared_pin <= 1'b0;
		idle(8);
		`CHK("frozen read", 1'b1, pin_read)
		clk_en <= 1'b1;
		idle(8);
		`CHK("pin read", 1'b0, pin_read)
		shared_pin <= 1'b1;
		wr(OFF_DIVIDER_REF_CONTROL, 8'ha0);
		idle(8);
		`CHK("analog pin", 1'b1, pin_an)
		`CHK("pin oe", 1'b0, pin_oe)
		`CHK("pin out", 1'b0, pin_out)
		`CHK("pin in en", 1'b0, pin_in_en)
		`CHK("pin read", 1'b0, pin_read)
		// divider switched off before the long idle that stands for sleep
		wr(OFF_DIVIDER_REF_CONTROL, 8'h20);
		idle(50);
		rd(OFF_DIVIDER_REF_CONTROL, 8'h20, "held");
		wr(OFF_DIVIDER_REF_CONTROL, 8'h00);
		idle(2);
		`CHK("analog pin", 1'b0, pin_an)
		`CHK("clamp", 1'b1, clamp)
		$display("test pin routing done");

		wr(OFF_DIVIDER_CODE_SELECT, 8'hff);
		idle(2);
		rd(OFF_DIVIDER_CODE_SELECT, 8'h1f, "code reg");
		`CHK("code out", 5'h1f, code)
		wr(12'h00c, 8'hff);
		rd(12'h00c, 8'h00, "unmapped");
		rd(OFF_DIVIDER_CODE_SELECT, 8'h1f, "code kept");
		wr(OFF_DIVIDER_REF_CONTROL, 8'ha0);
		$display("test code and unmapped done");

		// mid-run reset must restore every default
		resetn <= 1'b0;
		idle(3);
		resetn <= 1'b1;
		chk_reset();
		`CHK("code out", 5'h00, code)
		finish_test();
	end
endmodule

`default_nettype wire
